// ===== hw/csr_result_regs.sv
// Result, low-limit and bandwidth registers behind an Avalon-MM slave
`default_nettype none
module csr_result_regs
  import csr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [CSR_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter results, one entry per channel
  input wire csr_conv_t conv [CSR_CH],
  // Excitation generator settings
  output csr_exc_t exc
);
  logic [CSR_RES_W-1:0] res_q [CSR_CH];
  logic [CSR_RES_W-1:0] res_d [CSR_CH];
  logic ovr_q [CSR_CH];
  logic ovr_d [CSR_CH];
  logic [CSR_LL_W-1:0] ll_q, ll_d;
  logic [CSR_BW_W-1:0] bw_q, bw_d;
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [5:0] idx;
  logic req;

  assign idx = avs_address[7:2];
  assign req = avs_read | avs_write;
  // One wait state: answer on the cycle after the request first appears
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rd_q;

  genvar g;
  generate
    for (g = 0; g < CSR_CH; g++)
    begin : g_ch
      always_comb
      begin
        // Both bytes load from one conversion; bus writes never touch them
        res_d[g] = conv[g].valid ? conv[g].value : res_q[g];
        ovr_d[g] = conv[g].valid ? conv[g].overrange : ovr_q[g];
      end
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          res_q[g] <= CSR_RES_W'(0);
          ovr_q[g] <= 1'b0;
        end
        else
        begin
          res_q[g] <= res_d[g];
          ovr_q[g] <= ovr_d[g];
        end
      end
      AST_RESULT_LOAD: assert property (@(posedge clk) disable iff (reset)
        conv[g].valid |=> res_q[g] == $past(conv[g].value)
          && ovr_q[g] == $past(conv[g].overrange))
        else $error("result not loaded from conversion");
      AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (reset)
        !conv[g].valid |=> $stable(res_q[g]) && $stable(ovr_q[g]))
        else $error("result changed without conversion");
    end
  endgenerate

  always_comb
  begin
    ll_d = ll_q;
    bw_d = bw_q;
    ack_d = req & ~ack_q;
    rd_d = rd_q;
    if (req & ~ack_q)
    begin
      if (avs_write && avs_byteenable[0])
      begin
        if (idx == CSR_IDX_LOW_LIMIT)
          ll_d = avs_writedata[CSR_LL_W-1:0];
        if (idx == CSR_IDX_BANDWIDTH)
          bw_d = avs_writedata[CSR_BW_W-1:0];
      end
      rd_d = 32'h0000_0000;
      // Unmapped indices and reserved bits read zero
      case (idx)
        CSR_IDX_LOW_LIMIT: rd_d[CSR_LL_W-1:0] = ll_q;
        CSR_IDX_BANDWIDTH: rd_d[CSR_BW_W-1:0] = bw_q;
        CSR_IDX_CH1_LOW: rd_d[7:0] = {res_q[0][3:0], 3'h0, ovr_q[0]};
        CSR_IDX_CH1_HIGH: rd_d[7:0] = res_q[0][11:4];
        CSR_IDX_CH2_LOW: rd_d[7:0] = {res_q[1][3:0], 3'h0, ovr_q[1]};
        CSR_IDX_CH2_HIGH: rd_d[7:0] = res_q[1][11:4];
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ll_q <= CSR_RST_LOW_LIMIT[CSR_LL_W-1:0];
      bw_q <= CSR_RST_BANDWIDTH[CSR_BW_W-1:0];
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      ll_q <= ll_d;
      bw_q <= bw_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
    end
  end

  // Generator settings in kHz
  assign exc.spread_khz = CSR_KHZ_W'(bw_q * CSR_BW_STEP_KHZ);
  assign exc.low_khz = CSR_KHZ_W'(ll_q * CSR_LL_STEP_KHZ);

  AST_SPREAD_SCALE: assert property (@(posedge clk) disable iff (reset)
    exc.spread_khz == CSR_KHZ_W'(bw_q) * CSR_KHZ_W'(20))
    else $error("spread bandwidth scale wrong");
  AST_LOW_SCALE: assert property (@(posedge clk) disable iff (reset)
    exc.low_khz == CSR_KHZ_W'(ll_q) * CSR_KHZ_W'(10))
    else $error("low limit scale wrong");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
    (avs_read && !avs_waitrequest) |-> avs_readdata[31:8] == 24'h000000
      && !(idx == CSR_IDX_BANDWIDTH && avs_readdata[7:5] != 3'h0)
      && !((idx == CSR_IDX_CH1_LOW || idx == CSR_IDX_CH2_LOW)
      && avs_readdata[3:1] != 3'h0))
    else $error("reserved bits not zero");
  AST_HIGH_READ: assert property (@(posedge clk) disable iff (reset)
    (avs_read && avs_waitrequest && idx == CSR_IDX_CH1_HIGH)
      |=> avs_readdata[7:0] == $past(res_q[0][11:4]))
    else $error("high byte read wrong");
  AST_LOW_READ: assert property (@(posedge clk) disable iff (reset)
    (avs_read && avs_waitrequest && idx == CSR_IDX_CH2_LOW)
      |=> avs_readdata[7:4] == $past(res_q[1][3:0])
        && avs_readdata[0] == $past(ovr_q[1]))
    else $error("low byte read wrong");
  AST_RESET_CLEAR: assert property (@(posedge clk)
    $fell(reset) |-> res_q[0] == 12'h000 && res_q[1] == 12'h000)
    else $error("results not cleared by reset");

  // First cycle of a request, while the slave still holds it off
  sequence s_req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_read_at(logic [5:0] i);
    avs_read && avs_waitrequest && idx == i;
  endsequence

  sequence s_write_at(logic [5:0] i);
    avs_write && avs_waitrequest && avs_byteenable[0] && idx == i;
  endsequence

  // Exactly one wait state, so a master never stalls longer than a cycle
  AST_ONE_WAIT: assert property (@(posedge clk) disable iff (reset)
    s_req_open |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  AST_IDLE_NO_WAIT: assert property (@(posedge clk) disable iff (reset)
    (!avs_read && !avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");

  // Read data must stand until the next request is answered
  AST_READ_DATA_HOLD: assert property (@(posedge clk) disable iff (reset)
    (!avs_read && !avs_write) |=> $stable(avs_readdata))
    else $error("read data changed while idle");

  AST_BW_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_write_at(CSR_IDX_BANDWIDTH) |=> bw_q == $past(avs_writedata[CSR_BW_W-1:0]))
    else $error("bandwidth write lost");

  AST_LL_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_write_at(CSR_IDX_LOW_LIMIT) |=> ll_q == $past(avs_writedata[CSR_LL_W-1:0]))
    else $error("low limit write lost");

  // A write without byte 0 enabled must not land anywhere
  AST_BYTE0_REFUSED: assert property (@(posedge clk) disable iff (reset)
    (avs_write && avs_waitrequest && !avs_byteenable[0])
      |=> $stable(bw_q) && $stable(ll_q))
    else $error("write landed without byte enable");

  AST_RESULT_WRITE_IGNORED: assert property (@(posedge clk) disable iff (reset)
    (avs_write && idx >= CSR_IDX_CH1_LOW && idx <= CSR_IDX_CH2_HIGH
      && !conv[0].valid && !conv[1].valid)
      |=> $stable(res_q[0]) && $stable(res_q[1]))
    else $error("result register written by bus");

  AST_CH1_LOW_READ: assert property (@(posedge clk) disable iff (reset)
    s_read_at(CSR_IDX_CH1_LOW)
      |=> avs_readdata[7:4] == $past(res_q[0][3:0])
        && avs_readdata[3:1] == 3'h0
        && avs_readdata[0] == $past(ovr_q[0]))
    else $error("channel 1 low byte read wrong");

  AST_CH2_HIGH_READ: assert property (@(posedge clk) disable iff (reset)
    s_read_at(CSR_IDX_CH2_HIGH)
      |=> avs_readdata[7:0] == $past(res_q[1][11:4]))
    else $error("channel 2 high byte read wrong");

  AST_BW_READ: assert property (@(posedge clk) disable iff (reset)
    s_read_at(CSR_IDX_BANDWIDTH)
      |=> avs_readdata[4:0] == $past(bw_q) && avs_readdata[7:5] == 3'h0)
    else $error("bandwidth read wrong");

  // Anything outside the map reads as zero
  AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (reset)
    (avs_read && avs_waitrequest
      && (idx < CSR_IDX_LOW_LIMIT || idx > CSR_IDX_CH2_HIGH))
      |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_RESET_DEFAULTS: assert property (@(posedge clk)
    $fell(reset) |-> ll_q == CSR_RST_LOW_LIMIT[CSR_LL_W-1:0]
      && bw_q == CSR_RST_BANDWIDTH[CSR_BW_W-1:0]
      && !ovr_q[0] && !ovr_q[1])
    else $error("registers not at reset values");
endmodule
`default_nettype wire

// ===== inc/csr_pkg.sv
// Package for the capacitance sense result register block
`default_nettype none
package csr_pkg;
  localparam int CSR_CH = 2;
  localparam int CSR_RES_W = 12;
  localparam int CSR_AW = 8;
  // Printed offsets are not word multiples: they are indices, byte address = 4 * index
  localparam logic [5:0] CSR_IDX_LOW_LIMIT = 6'h06;
  localparam logic [5:0] CSR_IDX_BANDWIDTH = 6'h07;
  localparam logic [5:0] CSR_IDX_CH1_LOW = 6'h08;
  localparam logic [5:0] CSR_IDX_CH1_HIGH = 6'h09;
  localparam logic [5:0] CSR_IDX_CH2_LOW = 6'h0A;
  localparam logic [5:0] CSR_IDX_CH2_HIGH = 6'h0B;
  localparam logic [7:0] CSR_RST_LOW_LIMIT = 8'h1E;
  localparam logic [7:0] CSR_RST_BANDWIDTH = 8'h00;
  localparam logic [7:0] CSR_RST_RESULT = 8'h00;
  localparam int CSR_BW_W = 5;
  localparam int CSR_LL_W = 6;
  localparam int CSR_BW_STEP_KHZ = 20;
  localparam int CSR_LL_STEP_KHZ = 10;
  localparam int CSR_KHZ_W = 16;
  typedef struct packed {
    logic valid;
    logic overrange;
    logic [CSR_RES_W-1:0] value;
  } csr_conv_t;
  typedef struct packed {
    logic [CSR_KHZ_W-1:0] low_khz;
    logic [CSR_KHZ_W-1:0] spread_khz;
  } csr_exc_t;
endpackage
`default_nettype wire

// ===== bench/csr_conv_model.sv
// Converter model that delivers one finished result per call
`default_nettype none
module csr_conv_model
  import csr_pkg::*;
(
  input wire logic clk,
  output csr_conv_t conv [CSR_CH]
);
  timeunit 1ns;
  timeprecision 1ns;
  initial conv = '{default: '0};
  // Stale fields are inverted after the pulse so a late load shows up
  task automatic fire(input int ch, input logic ovr, input logic [11:0] v);
    conv[ch] <= '{1'b1, ovr, v};
    @(posedge clk);
    conv[ch] <= '{1'b0, ~ovr, ~v};
  endtask
endmodule
`default_nettype wire

// ===== bench/test_csr_result_regs.sv
// Self-checking bench for the result register block
`default_nettype none
module test_csr_result_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import csr_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic [7:0] adr = '0;
  logic rd_en = 0;
  logic wr_en = 0;
  logic [31:0] wdat = '0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic [31:0] junk;
  logic wait_rq;
  csr_conv_t conv [CSR_CH];
  csr_exc_t exc;
  int failures = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  csr_conv_model u_conv (.clk(clk), .conv(conv));
  csr_result_regs u_dut (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_rq), .conv(conv), .exc(exc));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held from just after a rise until a rise that sees waitrequest low
  task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] wd,
    output logic [31:0] d);
    adr <= {idx, 2'b00};
    rd_en <= ~w;
    wr_en <= w;
    wdat <= {24'h0, wd};
    do
      @(posedge clk);
    while (wait_rq !== 1'b0);
    d = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    acc(1'b0, idx, 8'h00, d);
    chk($sformatf("reg %h", idx), exp, d);
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 8; i < 12; i++) rchk(i[5:0], 32'h0);
    rchk(CSR_IDX_LOW_LIMIT, {24'h0, CSR_RST_LOW_LIMIT});
    rchk(6'h30, 32'h0);
    acc(1'b1, CSR_IDX_BANDWIDTH, 8'hFF, junk);
    rchk(CSR_IDX_BANDWIDTH, 32'h1F);
    chk("spread", 32'd620, {16'h0, exc.spread_khz});
    be <= 4'hE;
    acc(1'b1, CSR_IDX_BANDWIDTH, 8'h00, junk);
    be <= 4'hF;
    rchk(CSR_IDX_BANDWIDTH, 32'h1F);
    acc(1'b1, CSR_IDX_LOW_LIMIT, 8'h3F, junk);
    chk("low", 32'd630, {16'h0, exc.low_khz});
    u_conv.fire(0, 1'b1, 12'hABC);
    u_conv.fire(1, 1'b0, 12'h5A3);
    rchk(6'h08, 32'hC1);
    rchk(6'h09, 32'hAB);
    rchk(6'h0A, 32'h30);
    rchk(6'h0B, 32'h5A);
    for (int i = 8; i < 12; i++) acc(1'b1, i[5:0], 8'hFF, junk);
    rchk(6'h08, 32'hC1);
    rchk(6'h0B, 32'h5A);
    u_conv.fire(0, 1'b0, 12'h123);
    rchk(6'h08, 32'h30);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk(6'h09, 32'h0);
    summarize();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
